// ### acfg_pkg.sv
// Package for the converter mode configuration port.
// Assumes a single core clock; serial pins arrive asynchronously.
package acfg_pkg;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
  localparam logic [6:0] ADDR_POWER_DOWN = 7'h01;
  localparam logic [6:0] ADDR_TIMING = 7'h02;
  localparam logic [6:0] ADDR_DRIVER = 7'h03;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam int SOFT_RESET_BIT = 7;
  localparam int WORD_BITS = 16;
  localparam int ADDR_MSB = 14;
  localparam int DATA_MSB = 7;
  localparam int DIR_BIT = 15;
  localparam int PD_LSB = 0;
  localparam int INV_BIT = 3;
  localparam int PHASE_LSB = 1;
  localparam int DCS_BIT = 0;
  localparam int CUR_LSB = 4;
  localparam int TERM_BIT = 3;
  localparam int OFF_BIT = 2;
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_CMOS = 2'h0;
  localparam logic [1:0] MODE_LVDS = 2'h1;
  localparam logic [2:0] CUR_3P5MA = 3'h0;
  localparam logic [7:0] READ_UNDEF = 8'hFF;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_NAP_CH2 = 2'h1,
    PWR_NAP_BOTH = 2'h2,
    PWR_SLEEP = 2'h3
  } acfg_pwr_e;

  typedef struct packed {
    acfg_pwr_e power_down_field;
    logic clock_out_invert;
    logic [1:0] clock_out_phase;
    logic duty_cycle_stabilizer_enable;
    logic [2:0] lvds_current_field;
    logic internal_termination_enable;
    logic output_disable;
    logic [1:0] output_mode_field;
  } acfg_mode_s;
endpackage : acfg_pkg

// ### acfg_port.sv
// Mode configuration port: parallel strap decode or serial register access.
// Assumes all pin inputs are asynchronous to I_CORE_CLK and the serial
// clock is far slower than the core clock.
`timescale 1ns/1ps
module acfg_port (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_INTERFACE_SELECT,
  input wire logic I_CS_N,
  input wire logic I_SCK,
  input wire logic I_SDI,
  input wire logic I_SDO,
  output logic O_SDO,
  output logic O_SDO_OE,
  output acfg_pkg::acfg_pwr_e O_POWER_STATE,
  output logic O_SOFT_RESET_SLEEP,
  output logic O_CLOCK_OUT_INVERT,
  output logic [1:0] O_CLOCK_OUT_PHASE,
  output logic O_DCS_ENABLE,
  output logic [2:0] O_LVDS_CURRENT,
  output logic O_TERMINATION_ENABLE,
  output logic O_OUTPUT_DISABLE,
  output logic [1:0] O_OUTPUT_MODE
);
  // Two-flop synchronisers for every pin; only stage two is read.
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic par_mode;
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic sdo_in_s;
  logic sck_prev_q;
  logic cs_prev_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic in_xfer;

  assign par_mode = pin_sync_q[4];
  assign cs_n_s = pin_sync_q[3];
  assign sck_s = pin_sync_q[2];
  assign sdi_s = pin_sync_q[1];
  assign sdo_in_s = pin_sync_q[0];
  assign in_xfer = !par_mode && !cs_n_s;
  assign sck_rise = in_xfer && sck_s && !sck_prev_q;
  assign sck_fall = in_xfer && !sck_s && sck_prev_q;
  assign cs_rise = cs_n_s && !cs_prev_q && !par_mode;

  logic [4:0] pin_raw;
  assign pin_raw = {I_INTERFACE_SELECT, I_CS_N, I_SCK, I_SDI, I_SDO};

  for (genvar p = 0; p < 5; p++) begin : g_sync
    always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
        pin_meta_q[p] <= 1'b0;
        pin_sync_q[p] <= 1'b0;
      end else if (I_CE) begin
        pin_meta_q[p] <= pin_raw[p];
        pin_sync_q[p] <= pin_meta_q[p];
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else if (I_CE) begin
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_n_s;
    end
  end

  // Shift and count; counter saturates at 16 so later edges are dropped.
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [4:0] count_q;
  logic [4:0] count_d;
  logic full_word;
  logic take_bit;

  assign full_word = (count_q == 5'(acfg_pkg::WORD_BITS));
  assign take_bit = sck_rise && !full_word;
  assign shift_d = take_bit ? {shift_q[14:0], sdi_s} : shift_q;
  assign count_d = !in_xfer ? 5'h00 : (take_bit ? count_q + 5'h01 : count_q);

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
    end else if (I_CE) begin
      shift_q <= shift_d;
      count_q <= count_d;
    end
  end

  // Command fields: direction and read address after the eighth bit, write address and data after the sixteenth.
  logic is_read;
  logic [6:0] cmd_addr;
  logic [6:0] rd_addr;
  logic [7:0] cmd_data;
  // After eight bits the direction bit sits at bit 7, address below it
  assign is_read = shift_q[acfg_pkg::DATA_MSB];
  assign rd_addr = shift_q[acfg_pkg::DATA_MSB-1:0];
  assign cmd_addr = shift_q[acfg_pkg::ADDR_MSB -: 7];
  assign cmd_data = shift_q[acfg_pkg::DATA_MSB:0];

  // Registers: power, timing, driver. Commit at chip-select rise, so a
  // transfer cut short before sixteen edges never writes.
  logic [7:0] pwr_q;
  logic [7:0] tim_q;
  logic [7:0] drv_q;
  logic commit;
  logic soft_reset;
  logic sleep_q;

  assign commit = cs_rise && full_word && !shift_q[acfg_pkg::DIR_BIT];
  assign soft_reset = commit && (cmd_addr == acfg_pkg::ADDR_SOFT_RESET) &&
    cmd_data[acfg_pkg::SOFT_RESET_BIT];

  function automatic logic wr_hit(input logic [6:0] a, input logic [6:0] t);
    wr_hit = (a == t);
  endfunction : wr_hit

  // Other addresses match no enable, so they fall through untouched.
  logic pwr_we;
  logic tim_we;
  logic drv_we;
  assign pwr_we = commit && wr_hit(cmd_addr, acfg_pkg::ADDR_POWER_DOWN);
  assign tim_we = commit && wr_hit(cmd_addr, acfg_pkg::ADDR_TIMING);
  assign drv_we = commit && wr_hit(cmd_addr, acfg_pkg::ADDR_DRIVER);

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sleep_q <= 1'b0;
    end else if (I_CE) begin
      // Reset bit is never stored, so it is clear once the command ends.
      sleep_q <= soft_reset;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      pwr_q <= acfg_pkg::REG_RESET_VAL;
    end else if (I_CE) begin
      if (soft_reset) begin
        pwr_q <= acfg_pkg::REG_RESET_VAL;
      end else if (pwr_we) begin
        pwr_q <= cmd_data;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      tim_q <= acfg_pkg::REG_RESET_VAL;
    end else if (I_CE) begin
      if (soft_reset) begin
        tim_q <= acfg_pkg::REG_RESET_VAL;
      end else if (tim_we) begin
        tim_q <= cmd_data;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      drv_q <= acfg_pkg::REG_RESET_VAL;
    end else if (I_CE) begin
      if (soft_reset) begin
        drv_q <= acfg_pkg::REG_RESET_VAL;
      end else if (drv_we) begin
        drv_q <= cmd_data;
      end
    end
  end

  // Read-back: load after eight bits, shift MSB on falling edges.
  logic [7:0] rd_sel;
  logic [7:0] rd_q;
  logic rd_active_q;
  logic load_rd;
  logic sdo_low_d;

  always_comb begin
    unique case (rd_addr)
      acfg_pkg::ADDR_POWER_DOWN: rd_sel = pwr_q;
      acfg_pkg::ADDR_TIMING: rd_sel = tim_q;
      acfg_pkg::ADDR_DRIVER: rd_sel = drv_q;
      default: rd_sel = acfg_pkg::READ_UNDEF;
    endcase
  end

  // Bit 8 is taken on a rise; data bit 7 goes out at the next fall.
  assign load_rd = take_bit && (count_q == 5'h07) && shift_q[6];
  assign sdo_low_d = rd_active_q && !rd_q[7];

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      rd_q <= 8'h00;
      rd_active_q <= 1'b0;
    end else if (I_CE) begin
      if (!in_xfer) begin
        rd_active_q <= 1'b0;
      end else if (load_rd) begin
        rd_q <= 8'hFF;
        rd_active_q <= 1'b0;
      end else if (sck_fall && is_read && count_q == 5'h08 && !rd_active_q) begin
        rd_q <= rd_sel;
        rd_active_q <= 1'b1;
      end else if (sck_fall && rd_active_q && count_q > 5'h08) begin
        rd_q <= {rd_q[6:0], 1'b1};
      end
    end
  end

  // Parallel straps and register fields share one mode struct.
  acfg_pkg::acfg_mode_s mode_d;
  always_comb begin
    if (par_mode) begin
      mode_d.power_down_field = acfg_pkg::acfg_pwr_e'({sdi_s, sdo_in_s});
      mode_d.clock_out_invert = 1'b0;
      mode_d.clock_out_phase = 2'h0;
      mode_d.duty_cycle_stabilizer_enable = cs_n_s;
      mode_d.lvds_current_field = acfg_pkg::CUR_3P5MA;
      mode_d.internal_termination_enable = 1'b0;
      mode_d.output_disable = 1'b0;
      mode_d.output_mode_field = sck_s ? acfg_pkg::MODE_LVDS :
        acfg_pkg::MODE_CMOS;
    end else begin
      mode_d.power_down_field =
        acfg_pkg::acfg_pwr_e'(pwr_q[acfg_pkg::PD_LSB +: 2]);
      mode_d.clock_out_invert = tim_q[acfg_pkg::INV_BIT];
      mode_d.clock_out_phase = tim_q[acfg_pkg::PHASE_LSB +: 2];
      mode_d.duty_cycle_stabilizer_enable = tim_q[acfg_pkg::DCS_BIT];
      mode_d.lvds_current_field = drv_q[acfg_pkg::CUR_LSB +: 3];
      mode_d.internal_termination_enable = drv_q[acfg_pkg::TERM_BIT];
      mode_d.output_disable = drv_q[acfg_pkg::OFF_BIT];
      mode_d.output_mode_field = drv_q[acfg_pkg::MODE_LSB +: 2];
    end
  end

  // Registered outputs; the pin is only ever pulled low.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_SDO_OE <= 1'b0;
      O_SOFT_RESET_SLEEP <= 1'b0;
    end else if (I_CE) begin
      O_SDO_OE <= sdo_low_d && !par_mode;
      O_SOFT_RESET_SLEEP <= sleep_q;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_SDO <= 1'b0;
    end else if (I_CE) begin
      O_SDO <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_POWER_STATE <= acfg_pkg::PWR_NORMAL;
    end else if (I_CE) begin
      O_POWER_STATE <= mode_d.power_down_field;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_CLOCK_OUT_INVERT <= 1'b0;
    end else if (I_CE) begin
      O_CLOCK_OUT_INVERT <= mode_d.clock_out_invert;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_CLOCK_OUT_PHASE <= 2'h0;
    end else if (I_CE) begin
      O_CLOCK_OUT_PHASE <= mode_d.clock_out_phase;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_DCS_ENABLE <= 1'b0;
    end else if (I_CE) begin
      O_DCS_ENABLE <= mode_d.duty_cycle_stabilizer_enable;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_LVDS_CURRENT <= 3'h0;
    end else if (I_CE) begin
      O_LVDS_CURRENT <= mode_d.lvds_current_field;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_TERMINATION_ENABLE <= 1'b0;
    end else if (I_CE) begin
      O_TERMINATION_ENABLE <= mode_d.internal_termination_enable;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_OUTPUT_DISABLE <= 1'b0;
    end else if (I_CE) begin
      O_OUTPUT_DISABLE <= mode_d.output_disable;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_OUTPUT_MODE <= 2'h0;
    end else if (I_CE) begin
      O_OUTPUT_MODE <= mode_d.output_mode_field;
    end
  end
endmodule : acfg_port

// ### acfg_port_chk.sv
// Assertion checker for the mode configuration port.
// Bound to acfg_port; sees its ports only, one core clock domain.
`timescale 1ns/1ps
module acfg_chk (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_INTERFACE_SELECT,
  input wire logic I_CS_N,
  input wire logic I_SCK,
  input wire logic I_SDI,
  input wire logic I_SDO,
  input wire logic O_SDO,
  input wire logic O_SDO_OE,
  input wire acfg_pkg::acfg_pwr_e O_POWER_STATE,
  input wire logic O_SOFT_RESET_SLEEP,
  input wire logic O_CLOCK_OUT_INVERT,
  input wire logic [1:0] O_CLOCK_OUT_PHASE,
  input wire logic O_DCS_ENABLE,
  input wire logic [2:0] O_LVDS_CURRENT,
  input wire logic O_TERMINATION_ENABLE,
  input wire logic O_OUTPUT_DISABLE,
  input wire logic [1:0] O_OUTPUT_MODE
);
  // Eight quiet cycles cover the pin synchroniser latency
  default clocking dc @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);
  a_sdo_never_high: assert property (!O_SDO)
    else $error("sdo driven high");
  a_strap_fixed_vals: assert property (I_INTERFACE_SELECT[*8] |->
    !O_CLOCK_OUT_INVERT && O_CLOCK_OUT_PHASE == 2'h0 &&
    !O_OUTPUT_DISABLE && !O_SDO_OE) else $error("strap fixed values");
  a_strap_dcs: assert property (
    (I_INTERFACE_SELECT && $stable(I_CS_N))[*8] |-> O_DCS_ENABLE == I_CS_N)
    else $error("strap stabilizer");
  a_strap_outmode: assert property (
    (I_INTERFACE_SELECT && $stable(I_SCK))[*8] |->
    O_OUTPUT_MODE == {1'b0, I_SCK} && (!I_SCK || O_LVDS_CURRENT == 3'h0 &&
    !O_TERMINATION_ENABLE)) else $error("strap output mode");
  a_strap_power: assert property (
    (I_INTERFACE_SELECT && $stable({I_SDI, I_SDO}))[*8] |->
    O_POWER_STATE == {I_SDI, I_SDO}) else $error("strap power");
  a_idle_no_change: assert property (
    (!I_INTERFACE_SELECT && I_CS_N)[*8] |=> $stable({O_POWER_STATE,
    O_CLOCK_OUT_PHASE, O_LVDS_CURRENT, O_OUTPUT_MODE}))
    else $error("mode changed while idle");
  a_oe_idle_off: assert property (I_CS_N[*8] |-> !O_SDO_OE)
    else $error("sdo pulled outside frame");
  a_reset_clears: assert property ($rose(O_SOFT_RESET_SLEEP) |->
    ##[0:3] (O_POWER_STATE == 2'h0 && !O_DCS_ENABLE &&
    O_OUTPUT_MODE == 2'h0 && O_LVDS_CURRENT == 3'h0))
    else $error("soft reset left settings");
endmodule : acfg_chk

bind acfg_port acfg_chk i_acfg_chk (.*);

// ### acfg_host.sv
// Host model driving the serial configuration pins.
// Assumes the bench calls xfer; SDO arrives as the pulled-up wire.
`timescale 1ns/1ps
module acfg_host (
  input wire logic i_clk,
  input wire logic i_sdo,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_sdi
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b1;
  end
  // Clock stands low between frames; n other than 16 only on request
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    @(negedge i_clk) o_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_sdi <= (i < 16) ? w[15 - i] : ~o_sdi;
      repeat (4) @(negedge i_clk);
      o_sck <= 1'b1;
      repeat (4) @(negedge i_clk);
      if (i >= 8 && i < 16) rd[15 - i] = i_sdo;
      o_sck <= 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_cs_n <= 1'b1;
    o_sdi <= ~o_sdi;
    repeat (12) @(negedge i_clk);
  endtask : xfer
endmodule : acfg_host

// ### acfg_port_tb.sv
// Self-checking bench: strap rows first, then serial register cases.
// Assumes a 10 MHz core clock and the host model on the serial pins.
`timescale 1ns/1ps
module acfg_port_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b1;
  logic [3:0] strap = 4'h0;
  logic cs_n, sck, sdi, sdo_pin, sdo_wire, oe, slp, sdo_o;
  logic h_cs_n, h_sck, h_sdi;
  logic [7:0] rd, d1, d2, d3;
  logic [1:0] kb;
  logic [12:0] exp_mo;
  int bad_count = 0;
  int checked = 0;
  int slp_cnt = 0;
  int n;
  wire acfg_pkg::acfg_mode_s mo;
  wire logic [4:0] strap_view = {mo.duty_cycle_stabilizer_enable,
    mo.output_mode_field, mo.power_down_field};
  // Pins, then expected stabilizer, output mode, power state
  logic [8:0] rows [4] = '{9'h000, 9'h1B5, 9'h0C6, 9'h173};
  assign cs_n = sel ? strap[3] : h_cs_n;
  assign sck = sel ? strap[2] : h_sck;
  assign sdi = sel ? strap[1] : h_sdi;
  assign sdo_wire = oe ? sdo_o : 1'b1;
  assign sdo_pin = sel ? strap[0] : sdo_wire;
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (slp === 1'b1) slp_cnt <= slp_cnt + 1;
  acfg_port i_acfg_port (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1),
    .I_INTERFACE_SELECT(sel), .I_CS_N(cs_n), .I_SCK(sck), .I_SDI(sdi),
    .I_SDO(sdo_pin), .O_SDO(sdo_o), .O_SDO_OE(oe),
    .O_POWER_STATE(mo.power_down_field), .O_SOFT_RESET_SLEEP(slp),
    .O_CLOCK_OUT_INVERT(mo.clock_out_invert),
    .O_CLOCK_OUT_PHASE(mo.clock_out_phase),
    .O_DCS_ENABLE(mo.duty_cycle_stabilizer_enable),
    .O_LVDS_CURRENT(mo.lvds_current_field),
    .O_TERMINATION_ENABLE(mo.internal_termination_enable),
    .O_OUTPUT_DISABLE(mo.output_disable),
    .O_OUTPUT_MODE(mo.output_mode_field));
  acfg_host i_acfg_host (.i_clk(clk), .i_sdo(sdo_wire), .o_cs_n(h_cs_n),
    .o_sck(h_sck), .o_sdi(h_sdi));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_acfg_host.xfer({1'b0, a, d}, 16, rd);
  endtask : wr
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    i_acfg_host.xfer({1'b1, a, 8'hA5}, 16, rd);
    chk(rd, e);
  endtask : rdchk
  task automatic test_done;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    foreach (rows[r]) begin
      strap = rows[r][8:5];
      repeat (8) @(negedge clk);
      chk(strap_view, rows[r][4:0]);
    end
    sel = 1'b0;
    repeat (8) @(negedge clk);
    chk(mo, 13'h0000);
    wr(7'h00, 8'h80);
    for (int k = 0; k < 4; k++) begin
      kb = 2'(k);
      d1 = {6'h00, kb};
      d2 = {4'h0, kb[0], kb, 1'b1};
      d3 = {1'b0, kb, 1'b0, kb[1], kb[0], kb};
      wr(7'h01, d1);
      wr(7'h02, d2);
      wr(7'h03, d3);
      exp_mo = {d1[1:0], d2[3:0], d3[6:0]};
      chk(mo, exp_mo);
      rdchk(7'h01, d1);
      rdchk(7'h02, d2);
      rdchk(7'h03, d3);
      chk(mo, exp_mo);
    end
    rdchk(7'h00, 8'hFF);
    rdchk(7'h10, 8'hFF);
    wr(7'h05, 8'h00);
    i_acfg_host.xfer({1'b0, 7'h01, 8'h00}, 10, rd);
    chk(mo, exp_mo);
    i_acfg_host.xfer({1'b0, 7'h01, 8'h01}, 20, rd);
    chk(mo.power_down_field, 2'h1);
    n = slp_cnt;
    wr(7'h00, 8'h80);
    repeat (100) @(negedge clk);
    chk(16'(slp_cnt - n), 16'h0001);
    chk(mo, 13'h0000);
    rdchk(7'h03, 8'h00);
    test_done();
  end
endmodule : acfg_port_tb
